//--- hdl/aecr_consts.vh
`ifndef AECR_CONSTS_VH
`define AECR_CONSTS_VH
// Byte offsets of the register map.
`define AECR_OFS_GRP_EN 6'h00
`define AECR_OFS_EXT_CTRL 6'h01
`define AECR_OFS_VID_STAT 6'h02
`define AECR_OFS_AUD_STAT 6'h03
`define AECR_OFS_CS_MODE_LO 6'h04
`define AECR_OFS_CS_MODE_HI 6'h05
`define AECR_OFS_TONE1 6'h08
`define AECR_OFS_TONE2 6'h09
`define AECR_OFS_TONE3 6'h0A
`define AECR_OFS_TONE4 6'h0B
`define AECR_OFS_CSRAM_LO 6'h10
`define AECR_OFS_CSRAM_HI 6'h3F
// Field layout.
`define AECR_GRP_EN_MSB 3
`define AECR_GRP_EN_MASK 8'h0F
`define AECR_EXT_MASK 8'h17
`define AECR_EXT_SEL_MSB 2
`define AECR_EXT_TONE_BIT 4
// Reset values.
`define AECR_RST_BYTE 8'h00
// Channel-status RAM geometry: 48 bytes per pair, up to 8 pairs.
`define AECR_CSRAM_WORDS 9'h030
`define AECR_CSRAM_AW 9
`define AECR_CSRAM_PAIRS 8
// Read latency of the bus slave, in clock cycles.
`define AECR_READ_LATENCY 1
`endif

//--- hdl/aecr_csram.v
`include "aecr_consts.vh"

module aecr_csram (
  // Clock.
  input wire clk_in,
  // Write port.
  input wire wr_en_in,
  input wire [`AECR_CSRAM_AW-1:0] wr_addr_in,
  input wire [7:0] wr_data_in,
  // Registered read port.
  input wire [`AECR_CSRAM_AW-1:0] rd_addr_in,
  output reg [7:0] rd_data_out
);
  localparam DEPTH = `AECR_CSRAM_WORDS * `AECR_CSRAM_PAIRS;

  reg [7:0] mem_r [0:DEPTH-1];

  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_r[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_r[rd_addr_in];
  end
endmodule // aecr_csram

//--- hdl/aecr_readlat.v
`include "aecr_consts.vh"

module aecr_readlat (
  // Clock and reset.
  input wire clk_in,
  input wire srst_in,
  // Accepted read and its byte.
  input wire rd_take_in,
  input wire [7:0] rd_byte_in,
  // Answer.
  output reg rd_valid_out,
  output reg [7:0] rd_data_out
);
  always @(posedge clk_in) begin
    if (srst_in) begin
      rd_valid_out <= 1'b0;
      rd_data_out <= `AECR_RST_BYTE;
    end else begin
      rd_valid_out <= rd_take_in;
      rd_data_out <= rd_take_in ? rd_byte_in : `AECR_RST_BYTE;
    end
  end
endmodule // aecr_readlat

//--- hdl/aecr_regs.v
// Behaviour
// - Without the bus option, all controls and status use dedicated ports.
// - Bus slave register access is one byte wide for reads and writes.
// - A one-cycle strobe stores the data byte at the six-bit address.
// - With per-pair RAMs, strobed writes go to the pair chosen by extended control.
// - Group enable byte at 00h; its direct port behaves the same.
// - Extended control byte at 01h; its direct port behaves the same.
// - Video status at 02h, audio status at 03h, mirrored by output ports.
// - Channel-status mode bytes at 04h and 05h; direct form is 16 bits.
// - Four tone frequency bytes at 08h to 0Bh, each with its own port.
// - Channel-status RAM mapped at 10h to 3Fh; the direct address input is the byte offset itself, from 0.
// - Group enable bits 3:0 enable groups one to four; bits 7:4 reserved.
// - For HD and 3G, control packet embedded when any group is enabled.
// - With RAM parameter 2, extended bits 2:0 pick the pair written.
// - Extended bit 4 replaces all group audio with the tone generator.
// - Everything is sampled and driven on the single register clock.
// - Each read returns its byte with read-data-valid after the read latency.
// - Video status gives structure code, scan type and frame rate code.
`include "aecr_consts.vh"

module aecr_regs #(
  parameter USE_BUS = 1,
  parameter CSRAM_MODE = 2
) (
  // Clock and reset.
  input wire clk_in,
  input wire srst_in,
  // Bus slave.
  input wire [5:0] reg_base_addr_in,
  input wire [5:0] reg_burst_count_in,
  input wire reg_write_in,
  input wire [7:0] reg_writedata_in,
  input wire reg_read_in,
  output wire reg_waitrequest_out,
  output wire reg_readdatavalid_out,
  output wire [7:0] reg_readdata_out,
  // Direct control interface.
  input wire [7:0] audio_control_in,
  input wire [7:0] extended_control_in,
  input wire [15:0] cs_control_in,
  input wire [7:0] tone_rate_port_1_in,
  input wire [7:0] tone_rate_port_2_in,
  input wire [7:0] tone_rate_port_3_in,
  input wire [7:0] tone_rate_port_4_in,
  input wire [5:0] csram_addr_in,
  input wire csram_we_in,
  input wire [7:0] csram_data_in,
  output reg [7:0] video_status_out,
  output reg [7:0] audio_status_out,
  // Status from the embedding datapath.
  input wire [2:0] vid_struct_in,
  input wire vid_progressive_in,
  input wire [3:0] vid_rate_in,
  input wire vid_hd_or_3g_in,
  input wire [7:0] aud_state_in,
  // Settings towards the embedding datapath.
  output reg [3:0] group_enable_out,
  output reg ctrl_packet_enable_out,
  output reg tone_select_out,
  output reg [2:0] csram_pair_sel_out,
  output reg [15:0] cs_mode_out,
  output reg [7:0] tone_freq1_out,
  output reg [7:0] tone_freq2_out,
  output reg [7:0] tone_freq3_out,
  output reg [7:0] tone_freq4_out,
  // Channel-status RAM read port for the datapath.
  input wire [`AECR_CSRAM_AW-1:0] csram_rd_addr_in,
  output wire [7:0] csram_rd_data_out
);
  reg [7:0] grp_en_r;
  reg [7:0] ext_ctrl_r;
  reg [7:0] cs_lo_r;
  reg [7:0] cs_hi_r;
  reg [7:0] tone1_r;
  reg [7:0] tone2_r;
  reg [7:0] tone3_r;
  reg [7:0] tone4_r;
  reg [7:0] rd_byte;
  reg [7:0] grp_en;
  reg [7:0] ext_ctrl;
  reg ram_we;
  reg [5:0] ram_byte;
  reg [7:0] ram_data;
  wire [7:0] vid_byte;
  wire [2:0] pair;
  wire [`AECR_CSRAM_AW-1:0] ram_addr;

  // Maps a window address and pair select to a flat RAM word.
  function [`AECR_CSRAM_AW-1:0] ram_index;
    input [5:0] byte_ofs;
    input [2:0] pair_sel;
    reg [`AECR_CSRAM_AW-1:0] base;
    begin
      base = pair_sel * `AECR_CSRAM_WORDS;
      ram_index = base + {3'h0, byte_ofs};
    end
  endfunction

  // Tells whether an offset falls inside the RAM window.
  function in_window;
    input [5:0] ofs;
    begin
      in_window = (ofs >= `AECR_OFS_CSRAM_LO) && (ofs <= `AECR_OFS_CSRAM_HI);
    end
  endfunction

  // The slave never stalls, so the master's hold obligation never arises.
  assign reg_waitrequest_out = 1'b0;

  assign vid_byte = {vid_struct_in, vid_progressive_in, vid_rate_in};

  // Registered bus writes; reserved bits are masked off on entry.
  always @(posedge clk_in) begin
    if (srst_in) begin
      grp_en_r <= `AECR_RST_BYTE;
      ext_ctrl_r <= `AECR_RST_BYTE;
      cs_lo_r <= `AECR_RST_BYTE;
      cs_hi_r <= `AECR_RST_BYTE;
      tone1_r <= `AECR_RST_BYTE;
      tone2_r <= `AECR_RST_BYTE;
      tone3_r <= `AECR_RST_BYTE;
      tone4_r <= `AECR_RST_BYTE;
    end else if (USE_BUS != 0 && reg_write_in) begin
      case (reg_base_addr_in)
        `AECR_OFS_GRP_EN: grp_en_r <= reg_writedata_in & `AECR_GRP_EN_MASK;
        `AECR_OFS_EXT_CTRL: ext_ctrl_r <= reg_writedata_in & `AECR_EXT_MASK;
        `AECR_OFS_CS_MODE_LO: cs_lo_r <= reg_writedata_in;
        `AECR_OFS_CS_MODE_HI: cs_hi_r <= reg_writedata_in;
        `AECR_OFS_TONE1: tone1_r <= reg_writedata_in;
        `AECR_OFS_TONE2: tone2_r <= reg_writedata_in;
        `AECR_OFS_TONE3: tone3_r <= reg_writedata_in;
        `AECR_OFS_TONE4: tone4_r <= reg_writedata_in;
        default: begin
        end
      endcase
    end
  end

  // Selects between bus registers and the direct ports.
  always @* begin
    if (USE_BUS != 0) begin
      grp_en = grp_en_r;
      ext_ctrl = ext_ctrl_r;
      ram_we = reg_write_in && in_window(reg_base_addr_in);
      ram_byte = reg_base_addr_in - `AECR_OFS_CSRAM_LO;
      ram_data = reg_writedata_in;
    end else begin
      grp_en = audio_control_in & `AECR_GRP_EN_MASK;
      ext_ctrl = extended_control_in & `AECR_EXT_MASK;
      ram_we = csram_we_in;
      ram_byte = csram_addr_in;
      ram_data = csram_data_in;
    end
  end

  assign pair = (CSRAM_MODE == 2) ? ext_ctrl[`AECR_EXT_SEL_MSB:0] : 3'h0;
  assign ram_addr = ram_index(ram_byte, pair);

  // Outputs towards the datapath and the direct status ports.
  always @(posedge clk_in) begin
    if (srst_in) begin
      group_enable_out <= 4'h0;
      ctrl_packet_enable_out <= 1'b0;
      tone_select_out <= 1'b0;
      csram_pair_sel_out <= 3'h0;
      cs_mode_out <= 16'h0000;
      tone_freq1_out <= `AECR_RST_BYTE;
      tone_freq2_out <= `AECR_RST_BYTE;
      tone_freq3_out <= `AECR_RST_BYTE;
      tone_freq4_out <= `AECR_RST_BYTE;
      video_status_out <= `AECR_RST_BYTE;
      audio_status_out <= `AECR_RST_BYTE;
    end else begin
      group_enable_out <= grp_en[`AECR_GRP_EN_MSB:0];
      ctrl_packet_enable_out <= vid_hd_or_3g_in && (|grp_en[`AECR_GRP_EN_MSB:0]);
      tone_select_out <= ext_ctrl[`AECR_EXT_TONE_BIT];
      csram_pair_sel_out <= pair;
      if (USE_BUS != 0) begin
        cs_mode_out <= {cs_hi_r, cs_lo_r};
        tone_freq1_out <= tone1_r;
        tone_freq2_out <= tone2_r;
        tone_freq3_out <= tone3_r;
        tone_freq4_out <= tone4_r;
      end else begin
        cs_mode_out <= cs_control_in;
        tone_freq1_out <= tone_rate_port_1_in;
        tone_freq2_out <= tone_rate_port_2_in;
        tone_freq3_out <= tone_rate_port_3_in;
        tone_freq4_out <= tone_rate_port_4_in;
      end
      video_status_out <= vid_byte;
      audio_status_out <= aud_state_in;
    end
  end

  // Read decode; the RAM window is write-only and reads as zero.
  always @* begin
    case (reg_base_addr_in)
      `AECR_OFS_GRP_EN: rd_byte = grp_en_r;
      `AECR_OFS_EXT_CTRL: rd_byte = ext_ctrl_r;
      `AECR_OFS_VID_STAT: rd_byte = vid_byte;
      `AECR_OFS_AUD_STAT: rd_byte = aud_state_in;
      `AECR_OFS_CS_MODE_LO: rd_byte = cs_lo_r;
      `AECR_OFS_CS_MODE_HI: rd_byte = cs_hi_r;
      `AECR_OFS_TONE1: rd_byte = tone1_r;
      `AECR_OFS_TONE2: rd_byte = tone2_r;
      `AECR_OFS_TONE3: rd_byte = tone3_r;
      `AECR_OFS_TONE4: rd_byte = tone4_r;
      default: rd_byte = `AECR_RST_BYTE;
    endcase
  end

  aecr_readlat u_readlat (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .rd_take_in(reg_read_in && (USE_BUS != 0)),
    .rd_byte_in(rd_byte),
    .rd_valid_out(reg_readdatavalid_out),
    .rd_data_out(reg_readdata_out)
  );

  aecr_csram u_csram (
    .clk_in(clk_in),
    .wr_en_in(ram_we && !srst_in),
    .wr_addr_in(ram_addr),
    .wr_data_in(ram_data),
    .rd_addr_in(csram_rd_addr_in),
    .rd_data_out(csram_rd_data_out)
  );
endmodule // aecr_regs

//--- verif/aecr_monitor.sv
module aecr_monitor (
  input wire clk_in,
  input wire srst_in,
  input wire [5:0] reg_base_addr_in,
  input wire reg_write_in,
  input wire [7:0] reg_writedata_in,
  input wire reg_read_in,
  input wire reg_waitrequest_out,
  input wire reg_readdatavalid_out,
  input wire [7:0] reg_readdata_out,
  input wire [2:0] vid_struct_in,
  input wire vid_progressive_in,
  input wire [3:0] vid_rate_in,
  input wire vid_hd_or_3g_in,
  input wire [7:0] video_status_out,
  input wire [3:0] group_enable_out,
  input wire ctrl_packet_enable_out,
  input wire tone_select_out,
  input wire [7:0] aud_state_in,
  input wire [7:0] audio_status_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  a_no_wait: assert property (!reg_waitrequest_out) else $error("wait raised");
  a_read_latency: assert property (reg_read_in |=> reg_readdatavalid_out)
    else $error("read not answered");
  a_valid_cause: assert property (reg_readdatavalid_out |-> $past(reg_read_in))
    else $error("stray valid");
  a_group_write: assert property (reg_write_in && reg_base_addr_in == 6'h00 |->
    ##2 group_enable_out == $past(reg_writedata_in[3:0], 2)) else $error("group enable");
  a_tone_write: assert property (reg_write_in && reg_base_addr_in == 6'h01 |->
    ##2 tone_select_out == $past(reg_writedata_in[4], 2)) else $error("tone select");
  a_ctrl_packet: assert property (!$past(srst_in) |-> ctrl_packet_enable_out ==
    ($past(vid_hd_or_3g_in) && |group_enable_out)) else $error("control packet");
  a_video_status: assert property (!$past(srst_in) |-> video_status_out ==
    $past({vid_struct_in, vid_progressive_in, vid_rate_in})) else $error("video status");
  a_audio_status: assert property (!$past(srst_in) |-> audio_status_out ==
    $past(aud_state_in)) else $error("audio status");
  a_reserved_read: assert property (reg_read_in && (reg_base_addr_in[5:1] == 5'h03 ||
    reg_base_addr_in[5:2] == 4'h3 || reg_base_addr_in[5:4] != 2'h0) |=>
    reg_readdata_out == 8'h00) else $error("reserved read");
  c_read: cover property (reg_read_in ##1 reg_readdatavalid_out);
  c_group: cover property (reg_write_in && reg_base_addr_in == 6'h00);
  c_packet: cover property (ctrl_packet_enable_out);
endmodule // aecr_monitor

bind aecr_regs aecr_monitor u_mon (.clk_in, .srst_in, .reg_base_addr_in, .reg_write_in,
  .reg_writedata_in, .reg_read_in, .reg_waitrequest_out, .reg_readdatavalid_out,
  .reg_readdata_out, .vid_struct_in, .vid_progressive_in, .vid_rate_in, .vid_hd_or_3g_in,
  .video_status_out, .group_enable_out, .ctrl_packet_enable_out, .tone_select_out,
  .aud_state_in, .audio_status_out);

//--- verif/aecr_master.sv
module aecr_master (
  input wire clk_in,
  input wire reg_waitrequest_out,
  output logic [5:0] reg_base_addr_in = 6'h00,
  output logic [5:0] reg_burst_count_in = 6'h01,
  output logic reg_write_in = 1'b0,
  output logic [7:0] reg_writedata_in = 8'h00,
  output logic reg_read_in = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic access(input logic we, input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_base_addr_in = a;
    reg_burst_count_in = 6'h01;
    reg_write_in = we;
    reg_read_in = !we;
    reg_writedata_in = we ? d : ~reg_writedata_in;
    @(posedge clk_in);
    while (reg_waitrequest_out !== 1'b0) @(posedge clk_in);
  endtask
  // Strobes drop; address and data lines show the inverse of their last value.
  task automatic idle;
    @(negedge clk_in);
    reg_write_in = 1'b0;
    reg_read_in = 1'b0;
    reg_writedata_in = ~reg_writedata_in;
    reg_base_addr_in = ~reg_base_addr_in;
  endtask
endmodule // aecr_master

//--- verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [7:0] rnd = 8'h36;
  logic [7:0] dv = 8'h36;
  logic [8:0] ra = 9'h000;
  logic [7:0] sh [0:15];
  logic [7:0] exp_q [$];
  int bad_count = 0;
  int n_checks = 0;
  wire [5:0] ad, bc;
  wire wr, rd, wt, rdv, ts;
  wire [7:0] wd, q, rq, f1, f2, f3, f4, vs, aus;
  wire [3:0] ge;
  wire [2:0] ps;
  wire [15:0] cm;
  logic [7:0] ast = 8'h00;
  logic live = 1'b0;
  wire [3:0] dge;
  wire dts;
  wire [2:0] dps;
  wire [15:0] dcm;
  wire [7:0] dt1, dt2, dt3, dt4;
  aecr_master m (.clk_in, .reg_waitrequest_out(wt), .reg_base_addr_in(ad),
    .reg_burst_count_in(bc), .reg_write_in(wr), .reg_writedata_in(wd), .reg_read_in(rd));
  aecr_regs dut (.clk_in, .srst_in, .reg_base_addr_in(ad), .reg_burst_count_in(bc),
    .reg_write_in(wr), .reg_writedata_in(wd), .reg_read_in(rd), .reg_waitrequest_out(wt),
    .reg_readdatavalid_out(rdv), .reg_readdata_out(q), .audio_control_in(dv),
    .extended_control_in(~dv), .cs_control_in({dv, ~dv}), .tone_rate_port_1_in(dv),
    .tone_rate_port_2_in(~dv), .tone_rate_port_3_in(dv), .tone_rate_port_4_in(~dv),
    .csram_addr_in(dv[5:0]), .csram_we_in(dv[0] & ~dv[1]), .csram_data_in(dv),
    .video_status_out(vs), .audio_status_out(aus), .vid_struct_in(3'h5),
    .vid_progressive_in(1'b1), .vid_rate_in(4'hA), .vid_hd_or_3g_in(dv[7]),
    .aud_state_in(ast), .group_enable_out(ge), .ctrl_packet_enable_out(),
    .tone_select_out(ts), .csram_pair_sel_out(ps), .cs_mode_out(cm), .tone_freq1_out(f1),
    .tone_freq2_out(f2), .tone_freq3_out(f3), .tone_freq4_out(f4),
    .csram_rd_addr_in(ra), .csram_rd_data_out(rq));
  // Second instance without the bus: settings come straight from the direct ports.
  aecr_regs #(.USE_BUS(0)) dut_direct (.clk_in, .srst_in, .reg_base_addr_in(6'h00),
    .reg_burst_count_in(6'h01), .reg_write_in(1'b0), .reg_writedata_in(8'h00),
    .reg_read_in(1'b0), .reg_waitrequest_out(), .reg_readdatavalid_out(),
    .reg_readdata_out(), .audio_control_in(dv), .extended_control_in(~dv),
    .cs_control_in({dv, ~dv}), .tone_rate_port_1_in(dv), .tone_rate_port_2_in(~dv),
    .tone_rate_port_3_in(dv), .tone_rate_port_4_in(~dv), .csram_addr_in(dv[5:0]),
    .csram_we_in(dv[0] & ~dv[1]), .csram_data_in(dv), .video_status_out(),
    .audio_status_out(), .vid_struct_in(3'h5), .vid_progressive_in(1'b1),
    .vid_rate_in(4'hA), .vid_hd_or_3g_in(dv[7]), .aud_state_in(ast),
    .group_enable_out(dge), .ctrl_packet_enable_out(), .tone_select_out(dts),
    .csram_pair_sel_out(dps), .cs_mode_out(dcm), .tone_freq1_out(dt1),
    .tone_freq2_out(dt2), .tone_freq3_out(dt3), .tone_freq4_out(dt4),
    .csram_rd_addr_in(9'h000), .csram_rd_data_out());
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [7:0] wmask(input logic [5:0] a);
    case (a)
      6'h00: return 8'h0F;
      6'h01: return 8'h17;
      6'h04, 6'h05, 6'h08, 6'h09, 6'h0A, 6'h0B: return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    if (a < 6'h10 && wmask(a) != 8'h00) sh[a] = d & wmask(a);
    m.access(1'b1, a, d);
  endtask
  task automatic rd_reg(input logic [5:0] a);
    exp_q.push_back(a < 6'h10 ? sh[a] : 8'h00);
    m.access(1'b0, a, 8'h00);
  endtask
  initial forever #2.5 clk_in = ~clk_in;
  always @(negedge clk_in) dv <= lfsr(dv);
  always @(posedge clk_in) live <= !srst_in;
  // Direct outputs show the port values of the previous rising edge.
  always @(negedge clk_in) begin
    if (live) begin
      cmp("direct_group_enable", dv & 8'h0F, {4'h0, dge});
      cmp("direct_tone_select", {7'h00, ~dv[4]}, {7'h00, dts});
      cmp("direct_pair_select", ~dv & 8'h07, {5'h00, dps});
      cmp("direct_cs_mode_hi", dv, dcm[15:8]);
      cmp("direct_cs_mode_lo", ~dv, dcm[7:0]);
      cmp("direct_tone1", dv, dt1);
      cmp("direct_tone2", ~dv, dt2);
      cmp("direct_tone3", dv, dt3);
      cmp("direct_tone4", ~dv, dt4);
    end
  end
  always @(negedge clk_in) begin
    if (rdv === 1'b1) begin
      if (exp_q.size() == 0) cmp("spare valid", 8'h00, 8'h01);
      else cmp("readdata", exp_q.pop_front(), q);
    end
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    bad_count++;
    give_verdict();
  end
  initial begin
    for (int i = 0; i < 16; i++) sh[i] = 8'h00;
    sh[2] = {3'h5, 1'b1, 4'hA};
    rnd = lfsr(rnd);
    ast = rnd;
    sh[3] = rnd;
    repeat (12) @(negedge clk_in);
    srst_in = 1'b0;
    for (int a = 0; a < 64; a++) rd_reg(6'(a));
    for (int a = 0; a < 16; a++) begin
      rnd = lfsr(rnd);
      wr_reg(6'(a), rnd | 8'h10);
    end
    for (int a = 0; a < 64; a++) rd_reg(6'(a));
    m.idle();
    repeat (3) @(negedge clk_in);
    cmp("group_enable", sh[0] & 8'h0F, {4'h0, ge});
    cmp("tone_select", 8'h01, {7'h00, ts});
    cmp("pair_select", sh[1] & 8'h07, {5'h00, ps});
    cmp("cs_mode_lo", sh[4], cm[7:0]);
    cmp("cs_mode_hi", sh[5], cm[15:8]);
    cmp("tone_freq1", sh[8], f1);
    cmp("tone_freq2", sh[9], f2);
    cmp("tone_freq3", sh[10], f3);
    cmp("tone_freq4", sh[11], f4);
    cmp("video_status", sh[2], vs);
    cmp("audio_status", ast, aus);
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      wr_reg(6'h01, k ? 8'h00 : 8'h05);
      wr_reg(k ? 6'h10 : 6'h3F, rnd);
      m.idle();
      repeat (2) @(negedge clk_in);
      ra = k ? 9'd0 : 9'd287;
      repeat (2) @(negedge clk_in);
      cmp("csram", rnd, rq);
    end
    cmp("queue", 8'h00, 8'(exp_q.size()));
    give_verdict();
  end
endmodule // tb
